/* File: hw/kpl_pkg.sv */
// Shared constants, types and helpers for the keypad password lock
package kpl_pkg;
  // Timing
  localparam longint CLK_HZ     = 100_000_000;
  localparam longint UNLOCK_S   = 300;                        // Five minutes
  localparam longint UNLOCK_CYC = UNLOCK_S * CLK_HZ;
  localparam longint MSG_MS     = 500;                        // One message flash
  localparam longint MSG_CYC    = (MSG_MS * CLK_HZ) / 1000;
  localparam int     TMR_W      = 36;

  // Function numbers, BCD
  localparam logic [11:0] FUNC_ZERO  = 12'h000;
  localparam logic [11:0] FUNC_FIRST = 12'h001;               // first_function_entry
  localparam logic [11:0] FUNC_PW    = 12'h070;               // password_lock_function
  localparam logic [11:0] FUNC_DEF   = 12'h071;               // factory_default_function

  // Values, BCD
  localparam logic [15:0] VAL_ZERO = 16'h0000;
  localparam logic [15:0] PW_MAX   = 16'h0999;
  localparam logic [15:0] CODE_KEY = 16'h3552;               // Code of the zero password

  // Reset values and cursor limits
  localparam logic [1:0]  CUR_RST      = 2'h0;
  localparam logic [1:0]  CUR_MAX_FUNC = 2'h2;
  localparam logic [1:0]  CUR_MAX_VAL  = 2'h3;

  typedef enum logic [3:0] {
    ST_STATUS = 4'h1,
    ST_FUNC   = 4'h2,
    ST_VALUE  = 4'h4,
    ST_MSG    = 4'h8
  } kpl_state_type;

  typedef enum logic [2:0] {
    DISP_STATUS = 3'h0,
    DISP_FUNC   = 3'h1,
    DISP_VALUE  = 3'h2,
    DISP_END    = 3'h3,
    DISP_PASS   = 3'h4,
    DISP_ERR    = 3'h5
  } kpl_disp_type;

  // One decimal digit up or down, wrapping 9 <-> 0
  function automatic logic [3:0] kpl_bcd_step(input logic [3:0] d, input logic up);
    if (up) begin
      return (d >= 4'h9) ? 4'h0 : d + 4'h1;
    end
    return (d == 4'h0 || d > 4'h9) ? 4'h9 : d - 4'h1;
  endfunction

  // Hides a password: each digit offset by the matching digit of CODE_KEY
  function automatic logic [15:0] kpl_encode(input logic [15:0] pw);
    logic [15:0] r;
    r = VAL_ZERO;
    for (int i = 0; i < 4; i++) begin
      r[i*4 +: 4] = kpl_bcd_step(pw[i*4 +: 4], 1'b1);
      for (int k = 1; k < 10; k++) begin
        if (k < CODE_KEY[i*4 +: 4] + 1) begin
          r[i*4 +: 4] = (k == 1) ? pw[i*4 +: 4] : r[i*4 +: 4];
        end
      end
      for (int k = 0; k < 10; k++) begin
        if (k < CODE_KEY[i*4 +: 4]) begin
          r[i*4 +: 4] = kpl_bcd_step(r[i*4 +: 4], 1'b1);
        end
      end
    end
    return r;
  endfunction
endpackage

/* File: hw/kpl_bcd_edit.sv */
// Digit editor: steps the digit under the cursor of a BCD value
module kpl_bcd_edit (
  input  wire logic [15:0] value,
  input  wire logic [1:0]  cursor,
  input  wire logic        up,
  input  wire logic        down,
  input  wire logic        is_func,
  output logic      [15:0] result
);
  import kpl_pkg::*;

  // Other digits pass untouched; a function code of zero is refused
  always_comb begin
    logic [15:0] t;
    t = value;
    if (up || down) begin
      t[cursor*4 +: 4] = kpl_bcd_step(value[cursor*4 +: 4], up);
    end
    if (is_func && t[11:0] == FUNC_ZERO) begin
      t = value;
    end
    result = t;
  end
endmodule

/* File: hw/kpl_lock.sv */
// Keypad function selection with password parameter lock
// What this block does
// - Fn from status first shows function one
// - Left moves cursor left, right moves back
// - Function code never becomes all zeros
// - Password function shows 3552 when none stored
// - First arrow clears code, then shows entry
// - Stored password shows code other than 3552
// - Password accepted only from 0000 to 0999
// - New password flashes End, back to function
// - Locked: match flashes Pass, else Err
// - Stored password shown only in encoded form
// - Factory defaults leave password untouched
// - Committing 0000 disables password and lock
// - Locked commits outside the password function are refused with Err
// - Unlock lasts five minutes, renewed by keys
module kpl_lock #(
  parameter logic [kpl_pkg::TMR_W-1:0] UNLOCK_CYCLES = kpl_pkg::TMR_W'(kpl_pkg::UNLOCK_CYC),
  parameter logic [kpl_pkg::TMR_W-1:0] MSG_CYCLES    = kpl_pkg::TMR_W'(kpl_pkg::MSG_CYC)
) (
  input  wire logic                 CLK_SYS,
  input  wire logic                 RSTN,
  input  wire logic                 KEY_FUNC_SELECT,
  input  wire logic                 KEY_UP,
  input  wire logic                 KEY_DOWN,
  input  wire logic                 KEY_LEFT,
  input  wire logic                 KEY_RIGHT,
  input  wire logic                 KEY_ENTER,
  input  wire logic [15:0]          PARAM_RDATA,
  output kpl_pkg::kpl_disp_type     DISP_MODE,
  output logic      [15:0]          DISP_DIGITS,
  output logic      [1:0]           DISP_CURSOR,
  output logic      [11:0]          FUNC_NUM,
  output logic                      PARAM_WR,
  output logic      [15:0]          PARAM_WDATA,
  output logic                      DEFAULTS_REQ,
  output logic                      LOCKED
);
  import kpl_pkg::*;

  kpl_state_type      state;
  kpl_disp_type       msg;
  kpl_disp_type       next_msg;
  logic [11:0]        func;
  logic               fn_seen;
  logic [15:0]        val;
  logic               show_code;
  logic [1:0]         cursor;
  logic [15:0]        pw;
  logic               pw_set;
  logic [TMR_W-1:0]   unlock_cnt;
  logic [TMR_W-1:0]   msg_cnt;
  logic [15:0]        next_func;
  logic [15:0]        next_val;
  logic [15:0]        entry;
  logic               any_key;
  logic               arrow;
  logic               locked;
  logic               is_pw;
  logic               commit;
  logic               do_pw;
  logic               do_unlock;
  logic               do_wr;
  logic               do_def;

  // Key classes and lock state
  assign arrow   = KEY_UP || KEY_DOWN || KEY_LEFT || KEY_RIGHT;
  assign any_key = arrow || KEY_FUNC_SELECT || KEY_ENTER;
  assign locked  = pw_set && (unlock_cnt == '0);
  assign is_pw   = (func == FUNC_PW);
  assign commit  = (state == ST_VALUE) && KEY_ENTER && !KEY_FUNC_SELECT; // Fn outranks enter
  // An untouched code screen counts as an entry of zero
  assign entry   = show_code ? VAL_ZERO : val;

  // Digit editors for the function code and for the value
  kpl_bcd_edit u_func_edit (
    .value   ({4'h0, func}),
    .cursor  (cursor),
    .up      (KEY_UP),
    .down    (KEY_DOWN),
    .is_func (1'b1),
    .result  (next_func)
  );

  kpl_bcd_edit u_val_edit (
    .value   (val),
    .cursor  (cursor),
    .up      (KEY_UP),
    .down    (KEY_DOWN),
    .is_func (1'b0),
    .result  (next_val)
  );

  // Verdict on a read/enter in the value screen
  always_comb begin
    next_msg  = DISP_END;
    do_pw     = 1'b0;
    do_unlock = 1'b0;
    do_wr     = 1'b0;
    do_def    = 1'b0;
    if (is_pw) begin
      if (locked) begin
        if (entry == pw) begin
          do_unlock = 1'b1;
          next_msg  = DISP_PASS;
        end else begin
          next_msg  = DISP_ERR;
        end
      end else if (entry > PW_MAX) begin
        next_msg = DISP_ERR;
      end else begin
        do_pw = 1'b1;
      end
    end else if (locked) begin
      next_msg = DISP_ERR;
    end else if (func == FUNC_DEF) begin
      do_def = 1'b1;
    end else begin
      do_wr = 1'b1;
    end
  end

  // Screen sequencing; Fn backs out one level from function and value screens
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      state <= ST_STATUS;
    end else begin
      case (state)
        ST_STATUS: if (KEY_FUNC_SELECT) state <= ST_FUNC;
        ST_FUNC: begin
          if (KEY_FUNC_SELECT) begin
            state <= ST_STATUS;
          end else if (KEY_ENTER) begin
            state <= ST_VALUE;
          end
        end
        ST_VALUE: begin
          if (KEY_FUNC_SELECT) begin
            state <= ST_FUNC;
          end else if (KEY_ENTER) begin
            state <= ST_MSG;
          end
        end
        ST_MSG: if (msg_cnt == '0) state <= ST_FUNC;
        default: state <= ST_STATUS;
      endcase
    end
  end

  // Message flash timer; screen sequencing ignores keys while it runs
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      msg_cnt <= '0;
      msg     <= DISP_END;
    end else if (commit) begin
      msg_cnt <= MSG_CYCLES - 1'b1;
      msg     <= next_msg;
    end else if (state == ST_MSG && msg_cnt != '0) begin
      msg_cnt <= msg_cnt - 1'b1;
    end
  end

  // Function number; kept across status visits; Fn and enter outrank arrows
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      func    <= FUNC_FIRST;
      fn_seen <= 1'b0;
    end else if (state == ST_STATUS && KEY_FUNC_SELECT && !fn_seen) begin
      func    <= FUNC_FIRST;
      fn_seen <= 1'b1;
    end else if (state == ST_FUNC && !KEY_FUNC_SELECT && !KEY_ENTER && (KEY_UP || KEY_DOWN)) begin
      func <= next_func[11:0];
    end
  end

  // Cursor, shared by both edit screens
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      cursor <= CUR_RST;
    end else if (KEY_FUNC_SELECT || KEY_ENTER) begin
      cursor <= CUR_RST;
    end else if (state == ST_FUNC || (state == ST_VALUE && !show_code)) begin
      if (KEY_LEFT && cursor != ((state == ST_FUNC) ? CUR_MAX_FUNC : CUR_MAX_VAL)) begin
        cursor <= cursor + 2'h1;
      end else if (KEY_RIGHT && cursor != CUR_RST) begin
        cursor <= cursor - 2'h1;
      end
    end
  end

  // Value under edit; the password is only ever loaded encoded
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      val       <= VAL_ZERO;
      show_code <= 1'b0;
    end else if (state == ST_FUNC && KEY_ENTER && !KEY_FUNC_SELECT) begin
      val       <= is_pw ? kpl_encode(pw) : PARAM_RDATA;
      show_code <= is_pw;
    end else if (state == ST_VALUE && show_code && arrow) begin
      val       <= VAL_ZERO;
      show_code <= 1'b0;
    end else if (state == ST_VALUE && (KEY_UP || KEY_DOWN)) begin
      val <= next_val;
    end
  end

  // Stored password; the defaults request never touches it
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      pw     <= VAL_ZERO;
      pw_set <= 1'b0;
    end else if (commit && do_pw) begin
      pw     <= entry;
      pw_set <= (entry != VAL_ZERO);
    end
  end

  // Unlock window, renewed by every key while open
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      unlock_cnt <= '0;
    end else if (commit && do_unlock) begin
      unlock_cnt <= UNLOCK_CYCLES;
    end else if (unlock_cnt != '0) begin
      unlock_cnt <= any_key ? UNLOCK_CYCLES : unlock_cnt - 1'b1;
    end
  end

  // Registered outputs, one cycle behind the internal state
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      DISP_MODE    <= DISP_STATUS;
      DISP_DIGITS  <= VAL_ZERO;
      DISP_CURSOR  <= CUR_RST;
      FUNC_NUM     <= FUNC_FIRST;
      PARAM_WR     <= 1'b0;
      PARAM_WDATA  <= VAL_ZERO;
      DEFAULTS_REQ <= 1'b0;
      LOCKED       <= 1'b0;
    end else begin
      case (state)
        ST_FUNC:  DISP_MODE <= DISP_FUNC;
        ST_VALUE: DISP_MODE <= DISP_VALUE;
        ST_MSG:   DISP_MODE <= msg;
        default:  DISP_MODE <= DISP_STATUS;
      endcase
      DISP_DIGITS  <= (state == ST_VALUE) ? val : {4'h0, func};
      DISP_CURSOR  <= cursor;
      FUNC_NUM     <= func;
      PARAM_WR     <= commit && do_wr;
      PARAM_WDATA  <= val;
      DEFAULTS_REQ <= commit && do_def;
      LOCKED       <= locked;
    end
  end

  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);

  sequence seq_commit_end;
    commit && next_msg == DISP_END;
  endsequence
  sequence seq_flash_end;
    state == ST_MSG && msg == DISP_END;
  endsequence

  AST_FIRST: assert property (
    state == ST_STATUS && KEY_FUNC_SELECT && !fn_seen |=> state == ST_FUNC && func == FUNC_FIRST)
    else $error("first function entry not shown");
  AST_CURSOR: assert property (
    state == ST_FUNC && KEY_LEFT && !KEY_RIGHT && !KEY_FUNC_SELECT && !KEY_ENTER
    && cursor == CUR_RST |=> cursor == CUR_RST + 2'h1)
    else $error("cursor did not move left");
  AST_CURSOR_BACK: assert property (
    state == ST_FUNC && KEY_RIGHT && !KEY_LEFT && !KEY_FUNC_SELECT && !KEY_ENTER
    && cursor != CUR_RST |=> cursor == $past(cursor) - 2'h1)
    else $error("cursor did not move back right");
  AST_NONZERO: assert property (func != FUNC_ZERO)
    else $error("function number became zero");
  AST_CODE: assert property (
    state == ST_FUNC && KEY_ENTER && !KEY_FUNC_SELECT && is_pw && !pw_set
    |=> val == CODE_KEY && show_code)
    else $error("no-password code not shown");
  AST_CLEAR: assert property (
    state == ST_VALUE && show_code && arrow && !KEY_ENTER && !KEY_FUNC_SELECT
    |=> val == VAL_ZERO && !show_code)
    else $error("first arrow did not clear display");
  AST_HIDE: assert property (
    state == ST_VALUE && show_code |-> val == kpl_encode(pw) && (pw_set != (val == CODE_KEY)))
    else $error("encoded password display wrong");
  AST_RANGE: assert property (pw <= PW_MAX)
    else $error("stored password out of range");
  AST_END: assert property (
    seq_commit_end |=> seq_flash_end ##0 (msg_cnt == MSG_CYCLES - 1'b1))
    else $error("end message not flashed");
  AST_BACK: assert property (state == ST_MSG && msg_cnt == '0 |=> state == ST_FUNC)
    else $error("no return to function display");
  AST_VERDICT: assert property (
    commit && is_pw && locked && entry == pw |=> msg == DISP_PASS)
    else $error("matching password not accepted");
  AST_VERDICT_ERR: assert property (
    commit && is_pw && locked && entry != pw |=> msg == DISP_ERR)
    else $error("wrong password not refused");
  AST_KEEP: assert property (commit && do_def |=> pw == $past(pw) && DEFAULTS_REQ)
    else $error("defaults changed the password");
  AST_DISABLE: assert property (
    commit && is_pw && !locked && entry == VAL_ZERO |=> !pw_set && !locked)
    else $error("zero entry did not disable lock");
  AST_REFUSE: assert property (
    commit && locked && !is_pw |=> msg == DISP_ERR && !PARAM_WR && !DEFAULTS_REQ)
    else $error("locked commit not refused");
  AST_WINDOW: assert property (unlock_cnt != '0 && any_key |=> unlock_cnt == UNLOCK_CYCLES)
    else $error("unlock window not renewed");
  AST_WRAP: assert property (
    state == ST_VALUE && !show_code && KEY_UP && !KEY_ENTER && !KEY_FUNC_SELECT
    && cursor == CUR_RST && val[3:0] == 4'h9 |=> val[3:0] == 4'h0 && val[15:4] == $past(val[15:4]))
    else $error("digit did not wrap");
endmodule

/* File: tb/kpl_store.sv */
// Parameter store model on the far side of the keypad lock
module kpl_store (
  input  wire logic        clk,
  input  wire logic [11:0] func_num,
  input  wire logic        wr,
  input  wire logic [15:0] wdata,
  input  wire logic        defaults,
  input  wire logic [15:0] preset,
  output logic      [15:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem  [0:255];
  logic        held [0:255];

  // Nothing written yet, so every place reads the preset
  initial begin
    foreach (held[i]) held[i] = 1'b0;
  end

  // Fresh places read the bench preset so new values reach the lock
  assign rdata = held[func_num[7:0]] ? mem[func_num[7:0]] : preset;

  // Writes land at the current function; defaults forget them all
  always @(posedge clk) begin
    if (defaults) begin
      foreach (held[i]) held[i] <= 1'b0;
    end else if (wr) begin
      mem[func_num[7:0]]  <= wdata;
      held[func_num[7:0]] <= 1'b1;
    end
  end
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the keypad password lock
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import kpl_pkg::*;
  localparam int FN = 0, UP = 1, DN = 2, LT = 3, RT = 4, EN = 5;
  localparam int UNL = 200;
  logic          clk_sys = 1'b0;
  logic          rstn    = 1'b0;
  logic [5:0]    key     = 6'h00;
  logic [15:0]   preset  = 16'h0000;
  logic [15:0]   param_rdata, disp_digits, param_wdata, last_w, exp;
  logic [11:0]   func_num;
  logic [1:0]    disp_cursor;
  logic          param_wr, defaults_req, locked;
  kpl_disp_type  disp_mode;
  logic [31:0]   rng = 32'h0000_58f2;
  int            mismatches = 0, num_checks = 0, wr_cnt = 0, def_cnt = 0, n, w0;

  kpl_lock #(.UNLOCK_CYCLES(36'h00C8), .MSG_CYCLES(36'h0004)) i_kpl_lock (
    .CLK_SYS(clk_sys), .RSTN(rstn), .KEY_FUNC_SELECT(key[FN]), .KEY_UP(key[UP]),
    .KEY_DOWN(key[DN]), .KEY_LEFT(key[LT]), .KEY_RIGHT(key[RT]), .KEY_ENTER(key[EN]),
    .PARAM_RDATA(param_rdata), .DISP_MODE(disp_mode), .DISP_DIGITS(disp_digits),
    .DISP_CURSOR(disp_cursor), .FUNC_NUM(func_num), .PARAM_WR(param_wr),
    .PARAM_WDATA(param_wdata), .DEFAULTS_REQ(defaults_req), .LOCKED(locked));

  kpl_store i_kpl_store (.clk(clk_sys), .func_num(func_num), .wr(param_wr),
    .wdata(param_wdata), .defaults(defaults_req), .preset(preset), .rdata(param_rdata));

  // 100 MHz clock
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  // Count write and defaults pulses as the store sees them
  always @(posedge clk_sys) begin
    if (param_wr === 1'b1) begin
      wr_cnt++;
      last_w = param_wdata;
    end
    if (defaults_req === 1'b1) def_cnt++;
  end

  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  // Digit moved by n steps, wrapping 9 to 0
  function automatic logic [3:0] dig(input logic [3:0] d, input int k);
    return 4'((int'(d) + k) % 10);
  endfunction

  // Hidden form: each digit offset by the no-password code digit
  function automatic logic [15:0] enc(input logic [15:0] pw);
    logic [15:0] r;
    for (int i = 0; i < 4; i++) r[i*4 +: 4] = dig(pw[i*4 +: 4], int'(CODE_KEY[i*4 +: 4]));
    return r;
  endfunction

  function automatic logic [15:0] rnd_bcd();
    logic [15:0] r;
    for (int i = 0; i < 4; i++) r[i*4 +: 4] = 4'(xs() % 10);
    return r;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] want, input string what);
    num_checks++;
    if (got !== want) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask

  // One pulse, then two edges until the outputs show it
  task automatic press(input int i, input int k = 1);
    repeat (k) begin
      key[i] = 1'b1;
      @(posedge clk_sys);
      #1 key[i] = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
    end
  endtask

  task automatic wait_mode(input kpl_disp_type m);
    for (int k = 0; k < 40 && disp_mode !== m; k++) begin
      @(posedge clk_sys);
      #1;
    end
    chk(16'(disp_mode), 16'(m), "mode");
  endtask

  // First arrow only clears, then ups per digit moving left
  task automatic enter_pw(input logic [15:0] pw);
    press(RT);
    for (int d = 0; d < 4; d++) begin
      press(UP, int'(pw[d*4 +: 4]));
      press(LT);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Watchdog, far beyond the expected run
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    close_out();
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    #1;
    chk({4'h0, func_num}, 16'h0001, "reset func");
    chk({15'h0, locked}, 16'h0000, "reset lock");
    rstn = 1'b1;
    press(FN);
    chk({4'h0, func_num}, 16'h0001, "first");
    chk(disp_digits, 16'h0001, "first digits");
    press(DN);
    chk({4'h0, func_num}, 16'h0001, "no zero");
    press(LT);
    chk({14'h0, disp_cursor}, 16'h0001, "left");
    press(UP, 7);
    chk({4'h0, func_num}, 16'h0071, "up7");
    press(RT);
    chk({14'h0, disp_cursor}, 16'h0000, "right");
    press(DN);
    chk({4'h0, func_num}, 16'h0070, "down");
    $display("test navigate done");
    press(EN);
    chk(disp_digits, CODE_KEY, "no pw code");
    press(RT);
    chk(disp_digits, 16'h0000, "clear");
    press(UP, 3);
    press(LT);
    press(UP, 2);
    press(LT);
    press(UP);
    chk(disp_digits, 16'h0123, "entry");
    press(EN);
    chk(16'(disp_mode), 16'(DISP_END), "end");
    chk({15'h0, locked}, 16'h0001, "locked");
    wait_mode(DISP_FUNC);
    chk(disp_digits, 16'h0070, "back");
    $display("test set done");
    press(EN);
    chk(disp_digits, enc(16'h0123), "hidden");
    enter_pw(16'h0124);
    press(EN);
    chk(16'(disp_mode), 16'(DISP_ERR), "wrong pw");
    wait_mode(DISP_FUNC);
    press(RT, 2);
    press(UP);
    press(EN);
    press(EN);
    chk(16'(disp_mode), 16'(DISP_ERR), "locked commit");
    chk(16'(def_cnt), 16'h0000, "no defaults");
    wait_mode(DISP_FUNC);
    press(DN);
    press(EN);
    enter_pw(16'h0123);
    press(EN);
    chk(16'(disp_mode), 16'(DISP_PASS), "pass");
    chk({15'h0, locked}, 16'h0000, "unlocked");
    wait_mode(DISP_FUNC);
    $display("test unlock done");
    press(UP);
    press(EN);
    press(EN);
    wait_mode(DISP_FUNC);
    chk(16'(def_cnt), 16'h0001, "defaults");
    press(DN);
    press(EN);
    chk(disp_digits, enc(16'h0123), "pw kept");
    press(FN);
    press(RT, 2);
    press(LT);
    press(DN, 6);
    press(DN);
    chk({4'h0, func_num}, 16'h0010, "no zero");
    press(RT);
    // Fresh function each round; first round wraps 9 to 0
    for (int r = 0; r < 6; r++) begin
      press(RT);
      press(UP);
      preset = (r == 0) ? 16'h0999 : rnd_bcd();
      press(EN);
      chk(disp_digits, preset, "load");
      n = int'(xs() % 4) + 1;
      press(UP, n);
      press(LT);
      press(DN);
      exp = preset;
      exp[3:0] = dig(exp[3:0], n);
      exp[7:4] = dig(exp[7:4], 9);
      chk(disp_digits, exp, "edit");
      w0 = wr_cnt;
      press(EN);
      wait_mode(DISP_FUNC);
      chk(16'(wr_cnt - w0), 16'h0001, "write");
      chk(last_w, exp, "wdata");
    end
    $display("test params done");
    press(RT, 2);
    press(DN, 6);
    press(LT);
    press(UP, 6);
    press(RT);
    press(EN);
    enter_pw(16'h1000);
    press(EN);
    chk(16'(disp_mode), 16'(DISP_ERR), "range");
    wait_mode(DISP_FUNC);
    press(EN);
    chk(disp_digits, enc(16'h0123), "pw kept");
    press(FN);
    repeat (UNL + 20) @(posedge clk_sys);
    #1;
    chk({15'h0, locked}, 16'h0001, "relock");
    $display("test window done");
    press(EN);
    enter_pw(16'h0123);
    press(EN);
    wait_mode(DISP_FUNC);
    press(EN);
    press(RT);
    press(EN);
    wait_mode(DISP_FUNC);
    repeat (UNL + 20) @(posedge clk_sys);
    #1;
    chk({15'h0, locked}, 16'h0000, "disabled");
    press(EN);
    chk(disp_digits, CODE_KEY, "zero pw");
    $display("test disable done");
    close_out();
  end
endmodule
